// >>> rtl/tone_pkg.sv
package tone_pkg;
  // ***********************************************************
  // Field widths and encodings
  // ***********************************************************
  localparam int CODE_W = 8;
  localparam int PHASE_STEPS = 12;
  localparam logic [3:0] PHASE_LAST = 4'hB;
  localparam logic [7:0] CODE_RESET = 8'h02;
  localparam logic [7:0] CODE_MIN = 8'h01;
  localparam logic [1:0] DIV_BY1 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_BY4 = 2'h2;
  localparam logic [1:0] DIV_RESET = 2'h3;
  localparam logic [2:0] CHCTL_RESET = 3'h7;
  // ***********************************************************
  // Power modes decoded from the three power-select lines
  // ***********************************************************
  typedef enum logic [1:0] {PWR_DOWN, PWR_VREF, PWR_TONE, PWR_NORMAL} power_mode_t;
endpackage

// >>> rtl/tone_channel.sv
`timescale 1ns/1ps
module tone_channel (
  input wire logic clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic hold,
  input wire logic [7:0] code,
  output logic [3:0] phase,
  output logic step
);
  typedef struct packed {
    logic [7:0] div;
    logic [3:0] phase;
    logic step;
  } ch_state_t;
  ch_state_t st_r;
  ch_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.step = 1'b0;
    if (hold) begin
      // Common start point keeps equal codes in phase
      st_nxt.div = '0;
      st_nxt.phase = '0;
    end else if (tick) begin
      // Divide by 1+n, twelve steps per period
      if (st_r.div >= code) begin
        st_nxt.div = '0;
        st_nxt.step = 1'b1;
        st_nxt.phase = (st_r.phase == tone_pkg::PHASE_LAST) ? 4'h0 : st_r.phase + 4'h1;
      end else begin
        st_nxt.div = st_r.div + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign phase = st_r.phase;
  assign step = st_r.step;

  property p_hold_clears;
    @(posedge clk) disable iff (reset) hold |=> (phase == 4'h0);
  endproperty
  a_hold_clears: assert property (p_hold_clears) else $error("phase not cleared");

  property p_phase_wrap;
    @(posedge clk) disable iff (reset)
      (!hold && tick && st_r.div >= code && phase == tone_pkg::PHASE_LAST) |=> (phase == 4'h0);
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("phase did not wrap");
endmodule

// >>> rtl/tone_gen_ctrl.sv
`timescale 1ns/1ps
module tone_gen_ctrl (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic TONE_SOURCE_CLOCK,
  input wire logic TONE_GATE_PIN,
  input wire logic POWER_SELECT_BIT0,
  input wire logic POWER_SELECT_BIT1,
  input wire logic POWER_SELECT_BIT2,
  input wire logic [7:0] CH1_CODE,
  input wire logic [7:0] CH2_CODE,
  input wire logic CHANNEL_ONE_WAVE_SELECT,
  input wire logic CHANNEL_TWO_WAVE_SELECT,
  input wire logic [1:0] CLK_DIV_SEL,
  input wire logic CH1_HOLD,
  input wire logic CH2_HOLD,
  input wire logic LED_HOLD,
  input wire logic TONE_OUT_MUTE_SWITCH,
  input wire logic ENVELOPE_ENABLE,
  input wire logic CFG_WRITE,
  output logic [3:0] CH1_PHASE,
  output logic [3:0] CH2_PHASE,
  output logic CH1_TRAPEZOID,
  output logic CH2_TRAPEZOID,
  output logic CH1_ACTIVE,
  output logic CH2_ACTIVE,
  output logic CH1_POWERED,
  output logic CH2_POWERED,
  output logic LED_OUT,
  output logic TONE_LINE_AT_GROUND,
  output logic TONE_LINE_OE,
  output logic ENVELOPE_ON,
  output logic DIV_CODE_ERROR
);
  // ***********************************************************
  // Registered state
  // ***********************************************************
  typedef struct packed {
    logic [7:0] code1;
    logic [7:0] code2;
    logic wave1;
    logic wave2;
    logic [1:0] div_sel;
    logic [2:0] chctl;
    logic mute;
    logic env;
    logic src_q;
    logic [1:0] pre;
    logic tick;
    logic led;
    logic run1;
    logic run2;
    logic line_gnd;
    logic line_oe;
    logic pwr;
    logic bad_div;
  } ctl_state_t;
  ctl_state_t st_r;
  ctl_state_t st_nxt;
  tone_pkg::power_mode_t mode;
  logic gate_hold;
  logic tone_mode;
  logic div_hit;

  always_comb begin
    if (POWER_SELECT_BIT0) begin
      mode = tone_pkg::PWR_NORMAL;
    end else if (POWER_SELECT_BIT1) begin
      mode = tone_pkg::PWR_TONE;
    end else if (POWER_SELECT_BIT2) begin
      mode = tone_pkg::PWR_VREF;
    end else begin
      mode = tone_pkg::PWR_DOWN;
    end
  end

  assign tone_mode = (mode == tone_pkg::PWR_TONE) || (mode == tone_pkg::PWR_NORMAL);
  // Powered down counters are also held so they restart aligned
  assign gate_hold = !TONE_GATE_PIN || !tone_mode;

  // ***********************************************************
  // Generator clock prescaler on source clock rising edges
  // ***********************************************************
  always_comb begin
    unique case (st_r.div_sel)
      tone_pkg::DIV_BY1: div_hit = 1'b1;
      tone_pkg::DIV_BY2: div_hit = st_r.pre[0];
      tone_pkg::DIV_BY4: div_hit = &st_r.pre;
      // Prohibited code: generator stops rather than guess a rate
      default: div_hit = 1'b0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.src_q = TONE_SOURCE_CLOCK;
    st_nxt.tick = 1'b0;
    if (CFG_WRITE) begin
      st_nxt.code1 = (CH1_CODE < tone_pkg::CODE_MIN) ? tone_pkg::CODE_MIN : CH1_CODE;
      st_nxt.code2 = (CH2_CODE < tone_pkg::CODE_MIN) ? tone_pkg::CODE_MIN : CH2_CODE;
      st_nxt.wave1 = CHANNEL_ONE_WAVE_SELECT;
      st_nxt.wave2 = CHANNEL_TWO_WAVE_SELECT;
      st_nxt.div_sel = CLK_DIV_SEL;
      st_nxt.chctl = {LED_HOLD, CH1_HOLD, CH2_HOLD};
      st_nxt.mute = TONE_OUT_MUTE_SWITCH;
      st_nxt.env = ENVELOPE_ENABLE;
    end
    if (gate_hold) begin
      st_nxt.pre = '0;
    end else if (TONE_SOURCE_CLOCK && !st_r.src_q) begin
      st_nxt.pre = st_r.pre + 2'h1;
      st_nxt.tick = div_hit;
    end
    st_nxt.bad_div = (st_r.div_sel == tone_pkg::DIV_RESET);
    st_nxt.pwr = tone_mode;
    st_nxt.run1 = !gate_hold && !st_r.chctl[1];
    st_nxt.run2 = !gate_hold && !st_r.chctl[0];
    st_nxt.led = tone_mode && TONE_GATE_PIN && !st_r.chctl[2];
    if (!tone_mode) begin
      st_nxt.line_oe = 1'b0;
      st_nxt.line_gnd = 1'b0;
    end else if (!TONE_GATE_PIN) begin
      st_nxt.line_oe = !st_r.mute;
      st_nxt.line_gnd = !st_r.mute;
    end else begin
      st_nxt.line_oe = 1'b1;
      st_nxt.line_gnd = st_r.chctl[1] && st_r.chctl[0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_r <= '0;
      st_r.code1 <= tone_pkg::CODE_RESET;
      st_r.code2 <= tone_pkg::CODE_RESET;
      st_r.div_sel <= tone_pkg::DIV_RESET;
      st_r.chctl <= tone_pkg::CHCTL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ***********************************************************
  // Channels share one tick and the gate hold, so they start together
  // ***********************************************************
  tone_channel u_ch1 (
    .clk(CLK), .reset(RESET), .tick(st_r.tick), .hold(gate_hold || st_r.chctl[1]),
    .code(st_r.code1), .phase(CH1_PHASE), .step()
  );
  tone_channel u_ch2 (
    .clk(CLK), .reset(RESET), .tick(st_r.tick), .hold(gate_hold || st_r.chctl[0]),
    .code(st_r.code2), .phase(CH2_PHASE), .step()
  );

  assign CH1_TRAPEZOID = st_r.wave1;
  assign CH2_TRAPEZOID = st_r.wave2;
  assign CH1_ACTIVE = st_r.run1;
  assign CH2_ACTIVE = st_r.run2;
  assign CH1_POWERED = st_r.pwr;
  assign CH2_POWERED = st_r.pwr;
  assign LED_OUT = st_r.led;
  assign TONE_LINE_AT_GROUND = st_r.line_gnd;
  assign TONE_LINE_OE = st_r.line_oe;
  assign ENVELOPE_ON = st_r.env;
  assign DIV_CODE_ERROR = st_r.bad_div;

  // ***********************************************************
  // Checks
  // ***********************************************************
  sequence s_gate_low;
    !TONE_GATE_PIN;
  endsequence

  property p_led;
    @(posedge CLK) disable iff (RESET)
      LED_OUT |-> $past(TONE_GATE_PIN) && !$past(st_r.chctl[2]) && $past(tone_mode);
  endproperty
  a_led: assert property (p_led) else $error("LED high without cause");

  property p_power_down;
    @(posedge CLK) disable iff (RESET)
      !tone_mode |=> !LED_OUT && !TONE_LINE_OE && !CH1_POWERED && !CH1_ACTIVE;
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down outputs wrong");

  property p_gate_low_line;
    @(posedge CLK) disable iff (RESET)
      (s_gate_low and tone_mode) |=> (TONE_LINE_OE == !$past(st_r.mute)) && !CH2_ACTIVE;
  endproperty
  a_gate_low_line: assert property (p_gate_low_line) else $error("gate low line wrong");

  property p_gate_low_phase;
    @(posedge CLK) disable iff (RESET) s_gate_low ##1 s_gate_low |-> CH1_PHASE == 4'h0;
  endproperty
  a_gate_low_phase: assert property (p_gate_low_phase) else $error("counter not held");

  property p_same_phase;
    @(posedge CLK) disable iff (RESET)
      (st_r.code1 == st_r.code2 && !st_r.chctl[1] && !st_r.chctl[0] && CH1_PHASE == CH2_PHASE
       && u_ch1.st_r.div == u_ch2.st_r.div) |=> CH1_PHASE == CH2_PHASE;
  endproperty
  a_same_phase: assert property (p_same_phase) else $error("channels out of phase");

  property p_run_enable;
    @(posedge CLK) disable iff (RESET)
      CH1_ACTIVE |-> $past(TONE_GATE_PIN) && !$past(st_r.chctl[1]);
  endproperty
  a_run_enable: assert property (p_run_enable) else $error("channel runs without gate");

  property p_hold_ground;
    @(posedge CLK) disable iff (RESET)
      (TONE_GATE_PIN && tone_mode && st_r.chctl[1] && st_r.chctl[0]) |=> TONE_LINE_AT_GROUND;
  endproperty
  a_hold_ground: assert property (p_hold_ground) else $error("held line not grounded");

  property p_div_stop;
    @(posedge CLK) disable iff (RESET)
      (st_r.div_sel == tone_pkg::DIV_RESET) |=> !st_r.tick;
  endproperty
  a_div_stop: assert property (p_div_stop) else $error("tick with prohibited divider");

  property p_wave;
    @(posedge CLK) disable iff (RESET)
      CFG_WRITE |=> CH1_TRAPEZOID == $past(CHANNEL_ONE_WAVE_SELECT);
  endproperty
  a_wave: assert property (p_wave) else $error("wave select not taken");
endmodule

// >>> bench/tone_host_model.sv
`timescale 1ns/1ps
module tone_host_model (
  input wire logic clk,
  output logic [7:0] code1,
  output logic [7:0] code2,
  output logic [1:0] div,
  output logic [6:0] bits,
  output logic wr
);
  // *******
  // Codes the host may program at 512 kHz
  // *******
  logic [7:0] codes [13] = '{8'h3C, 8'h36, 8'h31, 8'h2C, 8'h22, 8'h1F, 8'h1C, 8'h19,
    8'hA2, 8'h6E, 8'h6A, 8'h14, 8'h0F};
  initial begin
    code1 = 8'h01;
    code2 = 8'h01;
    div = 2'h0;
    bits = 7'h1C;
    wr = 1'b0;
  end
  // Bits are {wave1, wave2, hold1, hold2, led hold, mute, envelope}
  task automatic put(input logic [7:0] c1, input logic [7:0] c2, input logic [1:0] d,
    input logic [6:0] b);
    @(negedge clk);
    code1 = c1;
    code2 = c2;
    div = d;
    bits = b;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
endmodule

// >>> bench/tone_gen_ctrl_test.sv
`timescale 1ns/1ps
module tone_gen_ctrl_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic tsc = 1'b0;
  logic gate = 1'b1;
  logic [2:0] psc = 3'h1;
  logic [7:0] c1, c2;
  logic [1:0] div;
  logic [6:0] bits;
  logic wr;
  logic [3:0] ph1, ph2;
  logic tr1, tr2, act1, act2, pw1, pw2, led, gnd, oe, env, derr;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [7:0] fc [6] = '{8'h01, 8'h2C, 8'h0F, 8'hFF, 8'h0F, 8'h01};
  logic [1:0] fd [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
  always #12.5 clk = ~clk;
  // Source clock at a quarter of the system clock
  always @(negedge clk) tsc <= cyc[1];
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      summarize();
    end
  end
  tone_host_model u_tone_host_model (.clk(clk), .code1(c1), .code2(c2), .div(div),
    .bits(bits), .wr(wr));
  tone_gen_ctrl u_tone_gen_ctrl (.CLK(clk), .RESET(reset), .TONE_SOURCE_CLOCK(tsc),
    .TONE_GATE_PIN(gate), .POWER_SELECT_BIT0(psc[0]), .POWER_SELECT_BIT1(psc[1]),
    .POWER_SELECT_BIT2(psc[2]), .CH1_CODE(c1), .CH2_CODE(c2),
    .CHANNEL_ONE_WAVE_SELECT(bits[6]), .CHANNEL_TWO_WAVE_SELECT(bits[5]),
    .CLK_DIV_SEL(div), .CH1_HOLD(bits[4]), .CH2_HOLD(bits[3]), .LED_HOLD(bits[2]),
    .TONE_OUT_MUTE_SWITCH(bits[1]), .ENVELOPE_ENABLE(bits[0]), .CFG_WRITE(wr),
    .CH1_PHASE(ph1), .CH2_PHASE(ph2), .CH1_TRAPEZOID(tr1), .CH2_TRAPEZOID(tr2),
    .CH1_ACTIVE(act1), .CH2_ACTIVE(act2), .CH1_POWERED(pw1), .CH2_POWERED(pw2),
    .LED_OUT(led), .TONE_LINE_AT_GROUND(gnd), .TONE_LINE_OE(oe), .ENVELOPE_ON(env),
    .DIV_CODE_ERROR(derr));
  // *******
  // Shared tasks
  // *******
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask
  // Second interval is exact; the first may start mid-count
  task automatic step_len(input logic sel, output int n);
    logic [3:0] p;
    for (int k = 0; k < 2; k++) begin
      p = sel ? ph2 : ph1;
      n = 0;
      while ((sel ? ph2 : ph1) === p && n < 3000) begin
        @(negedge clk);
        n++;
      end
    end
  endtask
  task automatic summarize();
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    int n;
    logic [15:0] e;
    repeat (6) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    chk({derr, led, oe}, 3'h5);
    u_tone_host_model.put(8'h01, 8'h01, 2'h3, 7'h00);
    settle();
    chk(derr, 1'b1);
    u_tone_host_model.put(8'h01, 8'h01, 2'h0, 7'h00);
    settle();
    chk(derr, 1'b0);
    $display("test divider done");
    for (int i = 0; i < 4; i++) begin
      psc = 3'(4'h8 >> i);
      settle();
      chk({pw1, pw2, act1, act2, led, oe}, (i > 1) ? 6'h3F : 6'h00);
    end
    psc = 3'h1;
    for (int i = 0; i < 8; i++) begin
      u_tone_host_model.put(8'h01, 8'h01, 2'h0, {2'b00, 3'(i), 2'b00});
      settle();
      e = {11'h000, ~i[2], ~i[1], ~i[0], 1'b1, i[2] & i[1]};
      chk({act1, act2, led, oe, gnd}, e);
    end
    $display("test power and holds done");
    gate = 1'b0;
    for (int m = 0; m < 2; m++) begin
      u_tone_host_model.put(8'h01, 8'h01, 2'h0, {5'h00, m[0], 1'b0});
      settle();
      chk({act1, act2, led, oe, gnd, ph1, ph2}, {3'h0, ~m[0], ~m[0], 8'h00});
    end
    for (int i = 0; i < 2; i++) begin
      u_tone_host_model.put(8'h01, 8'h01, 2'h0, {i[0], ~i[0], 4'h0, i[0]});
      settle();
      chk({tr1, tr2, env}, {i[0], ~i[0], i[0]});
    end
    $display("test gate and wave done");
    gate = 1'b1;
    for (int i = 0; i < 6; i++) begin
      u_tone_host_model.put(fc[i], fc[i], fd[i], 7'h00);
      step_len(1'b0, n);
      chk(16'(n), 16'(4 * (fc[i] + 1) * (1 << fd[i])));
    end
    // Host code table, channel two running the table in reverse order from channel one
    for (int j = 0; j < 13; j++) begin
      u_tone_host_model.put(u_tone_host_model.codes[j], u_tone_host_model.codes[12 - j], 2'h0,
        7'h00);
      step_len(1'b0, n);
      chk(16'(n), 16'(4 * (u_tone_host_model.codes[j] + 1)));
      step_len(1'b1, n);
      chk(16'(n), 16'(4 * (u_tone_host_model.codes[12 - j] + 1)));
    end
    // Code zero is outside the legal range and runs as code one
    u_tone_host_model.put(8'h00, 8'h00, 2'h0, 7'h00);
    step_len(1'b0, n);
    chk(16'(n), 16'h0008);
    $display("test frequency done");
    gate = 1'b0;
    u_tone_host_model.put(8'h05, 8'h05, 2'h0, 7'h01);
    settle();
    gate = 1'b1;
    for (int i = 0; i < 12; i++) begin
      repeat (7) @(negedge clk);
      chk(ph1, ph2);
    end
    chk(ph1, 4'h3);
    gate = 1'b0;
    settle();
    chk({ph1, led}, 5'h00);
    $display("test phase done");
    summarize();
  end
endmodule
